// >>> include/energy_defines.vh
// register indices, field positions, reset values and timing for the energy accumulator
// assumes: byte address = 4 x register index on a 32-bit apb bus
`ifndef ENERGY_DEFINES_VH
`define ENERGY_DEFINES_VH

// register indices
`define IDX_WAVEFORM_SELECT 8'h0d
`define IDX_ACCUMULATION_MODE 8'h0f
`define IDX_INT_ENABLE_TWO 8'hda
`define IDX_INT_ENABLE_THREE 8'hdb
`define IDX_INT_STATUS_TWO 8'hdd
`define IDX_INT_STATUS_THREE 8'hde
`define IDX_APPARENT_GAIN 8'h40
`define IDX_APPARENT_DIVIDER 8'h41
`define IDX_APPARENT_ENERGY 8'h42
`define IDX_APPARENT_ENERGY_RR 8'h43
`define IDX_REACTIVE_GAIN 8'h44
`define IDX_REACTIVE_ENERGY 8'h45
`define IDX_LINE_REACTIVE_ENERGY 8'h46
`define IDX_HALF_CYCLE_COUNT 8'h47
`define IDX_WAVEFORM 8'h48

// accumulation_mode fields
`define BIT_TAMPER_REACTIVE 1
`define BIT_ABSOLUTE_REACTIVE 2
// waveform_select fields
`define WAVE_RATE_LSB 0
`define WAVE_RATE_MSB 1
`define BIT_WAVE_SOURCE 2
// interrupt_enable_two / interrupt_status_two fields
`define BIT_APPARENT_HALF_FULL 0
`define BIT_APPARENT_OVERFLOW 1
// interrupt_enable_three / interrupt_status_three fields
`define BIT_CYCLE_END 2
`define BIT_WAVE_SAMPLE_ENABLE 3

// reset values
`define RST_BYTE 8'h00
`define RST_GAIN 12'h000
`define RST_HALF_CYCLE_COUNT 16'hffff

// timing
`define ACCUM_STEP_CLOCKS 5
`define CLK_MHZ 200
`define PULSE_LOW_MS 90
`define PULSE_LOW_CYCLES (`PULSE_LOW_MS * 1000 * `CLK_MHZ)

`endif

// >>> rtl/calibration_pulse.v
// calibration pulse generator: turns signed energy increments into active-low pulses
// assumes: step and delta come from the accumulation stage on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "energy_defines.vh"

module calibration_pulse #(
    parameter integer THRESHOLD_LOG2 = 25,
    parameter integer LOW_CYCLES = `PULSE_LOW_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire step,
    input wire [24:0] delta,
    output reg pulse_n
);

// ----------------------------------------------------------------
// residue and pulse width
// ----------------------------------------------------------------
reg [THRESHOLD_LOG2:0] residue_r;
reg [31:0] low_cnt_r;
wire [THRESHOLD_LOG2:0] delta_ext;
wire [THRESHOLD_LOG2:0] sum;
wire [THRESHOLD_LOG2:0] thresh;
wire fire_pos;
wire fire_neg;

assign delta_ext = {{(THRESHOLD_LOG2 - 24){delta[24]}}, delta};
assign sum = residue_r + delta_ext;
assign thresh = {{1{1'b0}}, 1'b1, {(THRESHOLD_LOG2 - 1){1'b0}}};
assign fire_pos = !sum[THRESHOLD_LOG2] && (sum >= thresh);
assign fire_neg = sum[THRESHOLD_LOG2] && ((~sum + 1'b1) >= thresh);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        residue_r <= {(THRESHOLD_LOG2 + 1){1'b0}};
        low_cnt_r <= 32'h0;
        pulse_n <= 1'b1;
    end else begin
        if (step) begin
            if (fire_pos)
                residue_r <= sum - thresh;
            else if (fire_neg)
                residue_r <= sum + thresh;
            else
                residue_r <= sum;
        end
        // output is active low; a pulse during a low phase is absorbed
        if (low_cnt_r != 32'h0) begin
            low_cnt_r <= low_cnt_r - 32'h1;
            pulse_n <= (low_cnt_r == 32'h1);
        end else if (step && (fire_pos || fire_neg)) begin
            low_cnt_r <= LOW_CYCLES;
            pulse_n <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// >>> rtl/energy_accumulator.v
// reactive and apparent energy accumulation stage with apb register access
// assumes: power, rms and zero-crossing inputs are synchronous to pclk
// Summary of operation
// - default mode adds reactive power signed
// - tamper bit: sign follows active power
// - tamper mode also drives pulse output
// - absolute bit: magnitude, skip active no-load
// - both bits set selects absolute mode
// - active-low pulse after reactive gain
// - line accumulation over programmed half cycles
// - cycle-end flag, enabled interrupt until cleared
// - restart at once, overwrite line result
// - count write clears, restarts at crossing
// - line energy same path and weight
// - apparent power is vrms times irms
// - apparent samples readable at selected rate
// - apparent gain one plus gain/4096
// - no apparent offset correction
// - 48-bit accumulation every five clocks
// - apparent accumulation uses unsigned addition
// - divide by divider, zero means one
// - read-reset register clears after read
// - unsigned energy, half-full on 24 bits
`timescale 1ns/1ps
`default_nettype none
`include "energy_defines.vh"

module energy_accumulator #(
    parameter integer PULSE_LOW_CYCLES = `PULSE_LOW_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [9:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire [23:0] active_power,
    input wire active_noload,
    input wire [23:0] reactive_power,
    input wire reactive_noload,
    input wire [23:0] voltage_rms,
    input wire [23:0] current_rms,
    input wire zero_cross,
    input wire sample_tick,
    output wire calibration_pulse_output_n,
    output wire energy_irq
);

// ----------------------------------------------------------------
// functions
// ----------------------------------------------------------------
function [24:0] gain_apply;
    input [24:0] x;
    input [11:0] g;
    reg signed [36:0] p;
    begin
        p = $signed(x) * $signed(g);
        gain_apply = x + p[36:12];
    end
endfunction

function [31:0] widen;
    input [23:0] v;
    begin
        widen = {8'h00, v};
    end
endfunction

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [7:0] waveform_select_r;
reg [7:0] accumulation_mode_r;
reg [7:0] interrupt_enable_two_r;
reg [7:0] interrupt_enable_three_r;
reg [7:0] interrupt_status_two_r;
reg [7:0] interrupt_status_three_r;
reg [11:0] apparent_gain_r;
reg [7:0] apparent_divider_r;
reg [11:0] reactive_gain_r;
reg [15:0] half_cycle_count_r;
reg [23:0] apparent_energy_r;
reg [47:0] apparent_acc_r;
reg [48:0] reactive_acc_r;
reg [48:0] line_acc_r;
reg [23:0] line_reactive_energy_r;
reg [15:0] half_cnt_r;
reg line_run_r;
reg [2:0] step_cnt_r;
reg [23:0] waveform_r;
reg [2:0] wave_div_r;
reg err_r;

localparam LINE_WAIT = 1'b0;
localparam LINE_RUN = 1'b1;

// ----------------------------------------------------------------
// apb decode
// ----------------------------------------------------------------
wire [7:0] idx = paddr[9:2];
wire setup = psel && !penable;
wire access = psel && penable;
wire wr = access && pwrite && !err_r;
wire rd = access && !pwrite && !err_r;
wire wr_wave = wr && (idx == `IDX_WAVEFORM_SELECT);
wire wr_mode = wr && (idx == `IDX_ACCUMULATION_MODE);
wire wr_en2 = wr && (idx == `IDX_INT_ENABLE_TWO);
wire wr_en3 = wr && (idx == `IDX_INT_ENABLE_THREE);
wire wr_st2 = wr && (idx == `IDX_INT_STATUS_TWO);
wire wr_st3 = wr && (idx == `IDX_INT_STATUS_THREE);
wire wr_again = wr && (idx == `IDX_APPARENT_GAIN);
wire wr_adiv = wr && (idx == `IDX_APPARENT_DIVIDER);
wire wr_rgain = wr && (idx == `IDX_REACTIVE_GAIN);
wire wr_count = wr && (idx == `IDX_HALF_CYCLE_COUNT);
wire rd_reset = rd && (idx == `IDX_APPARENT_ENERGY_RR);

assign pready = 1'b1;

reg [31:0] rdata;
reg hit;
always @* begin
    hit = 1'b1;
    rdata = 32'h0;
    case (idx)
        `IDX_WAVEFORM_SELECT: rdata = {24'h0, waveform_select_r};
        `IDX_ACCUMULATION_MODE: rdata = {24'h0, accumulation_mode_r};
        `IDX_INT_ENABLE_TWO: rdata = {24'h0, interrupt_enable_two_r};
        `IDX_INT_ENABLE_THREE: rdata = {24'h0, interrupt_enable_three_r};
        `IDX_INT_STATUS_TWO: rdata = {24'h0, interrupt_status_two_r};
        `IDX_INT_STATUS_THREE: rdata = {24'h0, interrupt_status_three_r};
        `IDX_APPARENT_GAIN: rdata = {20'h0, apparent_gain_r};
        `IDX_APPARENT_DIVIDER: rdata = {24'h0, apparent_divider_r};
        `IDX_APPARENT_ENERGY: rdata = widen(apparent_energy_r);
        `IDX_APPARENT_ENERGY_RR: rdata = widen(apparent_energy_r);
        `IDX_REACTIVE_GAIN: rdata = {20'h0, reactive_gain_r};
        `IDX_REACTIVE_ENERGY: rdata = widen(reactive_acc_r[48:25]);
        `IDX_LINE_REACTIVE_ENERGY: rdata = widen(line_reactive_energy_r);
        `IDX_HALF_CYCLE_COUNT: rdata = {16'h0, half_cycle_count_r};
        `IDX_WAVEFORM: rdata = widen(waveform_r);
        default: hit = 1'b0;
    endcase
end

// read data and error are captured in the setup cycle
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0;
        pslverr <= 1'b0;
        err_r <= 1'b0;
    end else if (setup) begin
        prdata <= pwrite ? 32'h0 : rdata;
        pslverr <= !hit;
        err_r <= !hit;
    end else if (access) begin
        pslverr <= 1'b0;
        err_r <= 1'b0;
    end
end

// ----------------------------------------------------------------
// accumulation step every five clocks
// ----------------------------------------------------------------
wire step = (step_cnt_r == `ACCUM_STEP_CLOCKS - 1);
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        step_cnt_r <= 3'h0;
    else
        step_cnt_r <= step ? 3'h0 : step_cnt_r + 3'h1;
end

// ----------------------------------------------------------------
// reactive path
// ----------------------------------------------------------------
wire [47:0] rms_product = voltage_rms * current_rms;
wire [24:0] apparent_power = gain_apply({1'b0, rms_product[47:24]}, apparent_gain_r);
wire [24:0] reactive_gained = gain_apply({reactive_power[23], reactive_power},
    reactive_gain_r);
wire tamper_mode = accumulation_mode_r[`BIT_TAMPER_REACTIVE];
wire abs_mode = accumulation_mode_r[`BIT_ABSOLUTE_REACTIVE];
reg [24:0] reactive_delta;
always @* begin
    reactive_delta = reactive_gained;
    if (reactive_noload) begin
        reactive_delta = 25'h0;
    end else if (abs_mode) begin
        if (active_noload)
            reactive_delta = 25'h0;
        else if (reactive_gained[24])
            reactive_delta = ~reactive_gained + 25'h1;
    end else if (tamper_mode && active_power[23]) begin
        reactive_delta = ~reactive_gained + 25'h1;
    end
end
wire [48:0] reactive_ext = {{24{reactive_delta[24]}}, reactive_delta};

// pulse follows the same increments as the energy register
calibration_pulse #(
    .THRESHOLD_LOG2(25),
    .LOW_CYCLES(PULSE_LOW_CYCLES)
) u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .step(step),
    .delta(reactive_delta),
    .pulse_n(calibration_pulse_output_n)
);

always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        reactive_acc_r <= 49'h0;
    else if (step)
        reactive_acc_r <= reactive_acc_r + reactive_ext;
end

// ----------------------------------------------------------------
// line cycle reactive accumulation
// ----------------------------------------------------------------
wire cycle_done = line_run_r && zero_cross &&
    (half_cnt_r + 16'h1 == half_cycle_count_r);
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        line_run_r <= LINE_WAIT;
        half_cnt_r <= 16'h0;
        line_acc_r <= 49'h0;
        line_reactive_energy_r <= 24'h0;
    end else if (wr_count) begin
        line_run_r <= LINE_WAIT;
        half_cnt_r <= 16'h0;
        line_acc_r <= 49'h0;
        line_reactive_energy_r <= 24'h0;
    end else begin
        case (line_run_r)
            LINE_WAIT: begin
                if (zero_cross && half_cycle_count_r != 16'h0) begin
                    line_run_r <= LINE_RUN;
                    half_cnt_r <= 16'h0;
                    line_acc_r <= 49'h0;
                end
            end
            LINE_RUN: begin
                if (cycle_done) begin
                    line_reactive_energy_r <= line_acc_r[48:25];
                    line_acc_r <= step ? reactive_ext : 49'h0;
                    half_cnt_r <= 16'h0;
                end else begin
                    if (zero_cross)
                        half_cnt_r <= half_cnt_r + 16'h1;
                    if (step)
                        line_acc_r <= line_acc_r + reactive_ext;
                end
            end
            default: line_run_r <= LINE_WAIT;
        endcase
    end
end

// ----------------------------------------------------------------
// apparent energy
// ----------------------------------------------------------------
// the gained apparent sample is never negative, so bit 24 is magnitude, not sign
wire [48:0] apparent_sum = {1'b0, apparent_acc_r} +
    {24'h0, apparent_power};
wire [7:0] divisor = (apparent_divider_r == 8'h00) ? 8'h01 : apparent_divider_r;
wire [47:0] apparent_div = apparent_sum[47:0] / {40'h0, divisor};
wire apparent_ovf = step && apparent_sum[48];
wire apparent_half = step && apparent_div[47] && !apparent_energy_r[23];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        apparent_acc_r <= 48'h0;
        apparent_energy_r <= 24'h0;
    end else if (rd_reset) begin
        apparent_acc_r <= 48'h0;
        apparent_energy_r <= 24'h0;
    end else if (step) begin
        apparent_acc_r <= apparent_sum[47:0];
        apparent_energy_r <= apparent_div[47:24];
    end
end

// ----------------------------------------------------------------
// waveform sampling
// ----------------------------------------------------------------
wire [1:0] wave_rate = waveform_select_r[`WAVE_RATE_MSB:`WAVE_RATE_LSB];
wire [2:0] wave_mask = (3'h1 << wave_rate) - 3'h1;
wire wave_take = sample_tick && ((wave_div_r & wave_mask) == 3'h0) &&
    interrupt_enable_three_r[`BIT_WAVE_SAMPLE_ENABLE];
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wave_div_r <= 3'h0;
        waveform_r <= 24'h0;
    end else begin
        if (sample_tick)
            wave_div_r <= wave_div_r + 3'h1;
        if (wave_take)
            waveform_r <= waveform_select_r[`BIT_WAVE_SOURCE] ?
                apparent_power[23:0] : reactive_gained[23:0];
    end
end

// ----------------------------------------------------------------
// configuration and flags
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        waveform_select_r <= `RST_BYTE;
        accumulation_mode_r <= `RST_BYTE;
        interrupt_enable_two_r <= `RST_BYTE;
        interrupt_enable_three_r <= `RST_BYTE;
        apparent_gain_r <= `RST_GAIN;
        apparent_divider_r <= `RST_BYTE;
        reactive_gain_r <= `RST_GAIN;
        half_cycle_count_r <= `RST_HALF_CYCLE_COUNT;
        interrupt_status_two_r <= `RST_BYTE;
        interrupt_status_three_r <= `RST_BYTE;
    end else begin
        if (wr_wave)
            waveform_select_r <= pwdata[7:0];
        if (wr_mode)
            accumulation_mode_r <= pwdata[7:0];
        if (wr_en2)
            interrupt_enable_two_r <= pwdata[7:0];
        if (wr_en3)
            interrupt_enable_three_r <= pwdata[7:0];
        if (wr_again)
            apparent_gain_r <= pwdata[11:0];
        if (wr_adiv)
            apparent_divider_r <= pwdata[7:0];
        if (wr_rgain)
            reactive_gain_r <= pwdata[11:0];
        if (wr_count)
            half_cycle_count_r <= pwdata[15:0];
        // write one to clear; a new event in the same cycle wins
        interrupt_status_two_r <= ((interrupt_status_two_r &
            ~(wr_st2 ? pwdata[7:0] : 8'h00)) |
            ({7'h0, apparent_half} << `BIT_APPARENT_HALF_FULL) |
            ({7'h0, apparent_ovf} << `BIT_APPARENT_OVERFLOW)) & 8'h03;
        interrupt_status_three_r <= ((interrupt_status_three_r &
            ~(wr_st3 ? pwdata[7:0] : 8'h00)) |
            ({7'h0, cycle_done} << `BIT_CYCLE_END)) & 8'h04;
    end
end

wire [7:0] en3_flags = interrupt_enable_three_r & 8'h04;
assign energy_irq = |(interrupt_status_two_r & interrupt_enable_two_r) ||
    |(interrupt_status_three_r & en3_flags);

endmodule
`default_nettype wire

// >>> tb/energy_checker.sv
// checker for the energy accumulator ports, bound into the design top
// assumes: one clock domain pclk, asynchronous active-low presetn
`timescale 1ns/1ps
`default_nettype none
module energy_checker #(
    parameter integer PULSE_LOW_CYCLES = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [9:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [23:0] active_power,
    input wire active_noload,
    input wire [23:0] reactive_power,
    input wire reactive_noload,
    input wire [23:0] voltage_rms,
    input wire [23:0] current_rms,
    input wire zero_cross,
    input wire sample_tick,
    input wire calibration_pulse_output_n,
    input wire energy_irq
);
    // ----------------
    // write shadows
    // ----------------
    wire [7:0] idx = paddr[9:2];
    wire rd = psel && penable && !pwrite;
    wire wr = psel && penable && pwrite;
    wire hit = idx inside {8'h0d, 8'h0f, [8'hda:8'hdb], [8'hdd:8'hde], [8'h40:8'h48]};
    wire clr = wr && idx inside {[8'hda:8'hdb], [8'hdd:8'hde]};
    logic [7:0] mode_s;
    logic [2:0] en_s;
    logic [1:0] zc_n;
    int low_cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_s <= 8'h00;
            en_s <= 3'b000;
            zc_n <= 2'd0;
            low_cnt <= 0;
        end else begin
            if (wr && idx == 8'h0f)
                mode_s <= pwdata[7:0];
            if (wr && idx == 8'hda)
                en_s[1:0] <= pwdata[1:0];
            if (wr && idx == 8'hdb)
                en_s[2] <= pwdata[2];
            if (wr && idx == 8'h47)
                zc_n <= 2'd0;
            else if (zero_cross && zc_n != 2'd2)
                zc_n <= zc_n + 2'd1;
            low_cnt <= calibration_pulse_output_n ? 0 : low_cnt + 1;
        end
    end
    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_unmapped_refused: assert property (
        psel && penable && !hit |-> pslverr && prdata == 32'h0) else $error("unmapped access");
    a_mapped_accepted: assert property (
        psel && penable && hit |-> !pslverr) else $error("mapped access refused");
    a_mode_readback: assert property (
        rd && idx == 8'h0f |-> prdata == {24'h0, mode_s}) else $error("mode readback");
    a_energy_width: assert property (
        rd && idx inside {[8'h42:8'h46]} |-> prdata[31:24] == 8'h00) else $error("energy width");
    a_line_cleared: assert property (
        rd && idx == 8'h46 && zc_n != 2'd2 |-> prdata == 32'h0) else $error("line not cleared");
    a_irq_held: assert property (
        energy_irq && !clr |=> energy_irq) else $error("interrupt dropped");
    a_irq_enabled: assert property (
        energy_irq |-> en_s != 3'b000) else $error("interrupt without enable");
    a_pulse_length: assert property (
        $rose(calibration_pulse_output_n) |-> low_cnt == PULSE_LOW_CYCLES) else $error("pulse");
    cover property ($fell(calibration_pulse_output_n));
    cover property (rd && idx == 8'h43);
    cover property ($rose(energy_irq));
endmodule
bind energy_accumulator energy_checker #(.PULSE_LOW_CYCLES(PULSE_LOW_CYCLES)) chk (.*);
`default_nettype wire

// >>> tb/line_source.sv
// source of zero-crossing and waveform tick pulses
// assumes: HALF_PERIOD a multiple of five, so crossings never meet a step edge
`timescale 1ns/1ps
`default_nettype none
module line_source #(
    parameter integer HALF_PERIOD = 40
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic zero_cross,
    output logic sample_tick
);
    int c;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c <= 0;
            zero_cross <= 1'b0;
            sample_tick <= 1'b0;
        end else begin
            c <= c == HALF_PERIOD - 1 ? 0 : c + 1;
            zero_cross <= c == HALF_PERIOD - 4;
            sample_tick <= c[2:0] == 3'd1;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the energy accumulator with a behavioural model
// assumes: design, checker and line_source are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk, presetn, psel, penable, pwrite, active_noload, reactive_noload;
    logic [9:0] paddr;
    logic [31:0] pwdata;
    logic [23:0] active_power, reactive_power, voltage_rms, current_rms;
    wire [31:0] prdata;
    wire pready, pslverr, zero_cross, sample_tick, calibration_pulse_output_n, energy_irq;
    int seed = 49;
    int bad_count = 0;
    int total_checks = 0;
    logic [31:0] sh [0:255];
    logic [48:0] ra, la;
    logic [47:0] aa;
    logic [23:0] lval, wv;
    logic lrun, cyc;
    int sc, lcnt, wc;
    longint x, d, y;
    wire [7:0] idx = paddr[9:2];
    byte unsigned rw [8] = '{8'h0d, 8'h0f, 8'hda, 8'hdb, 8'h40, 8'h41, 8'h44, 8'h47};
    energy_accumulator #(.PULSE_LOW_CYCLES(8)) dut (.*);
    line_source src (.pclk(pclk), .presetn(presetn), .zero_cross(zero_cross),
        .sample_tick(sample_tick));
    // ----------------
    // reference model
    // ----------------
    function automatic logic [31:0] wmask(input logic [7:0] i);
        case (i)
            8'h0d, 8'h0f, 8'hda, 8'hdb: wmask = 32'hff;
            8'h40, 8'h44: wmask = 32'hfff;
            8'h41: wmask = 32'hff;
            8'h47: wmask = 32'hffff;
            default: wmask = 32'h0;
        endcase
    endfunction
    function automatic logic [31:0] expv(input logic [7:0] i);
        logic [47:0] dv;
        dv = aa / (sh[8'h41] | 32'(sh[8'h41] == 0));
        case (i)
            8'h42, 8'h43: expv = 32'(dv[47:24]);
            8'h45: expv = 32'(ra[48:25]);
            8'h46: expv = 32'(lval);
            8'h48: expv = 32'(wv);
            8'hde: expv = {29'h0, cyc, 2'b00};
            default: expv = sh[i];
        endcase
    endfunction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            foreach (sh[n])
                sh[n] = 32'h0;
            sh[8'h47] = 32'hffff;
            {ra, la, aa, lval, wv, lrun, cyc, sc, lcnt, wc} = '0;
        end else begin
            x = longint'($signed(reactive_power));
            x = x + ((x * longint'($signed(sh[8'h44][11:0]))) >>> 12);
            if (reactive_noload || (sh[8'h0f][2] && active_noload))
                d = 0;
            else if (sh[8'h0f][2])
                d = x < 0 ? -x : x;
            else
                d = sh[8'h0f][1] && active_power[23] ? -x : x;
            y = x;
            x = (longint'(voltage_rms) * current_rms) >> 24;
            x = x + ((x * longint'($signed(sh[8'h40][11:0]))) >>> 12);
            if (sample_tick && sh[8'hdb][3] && (wc & ((1 << sh[8'h0d][1:0]) - 1)) == 0)
                wv = 24'(sh[8'h0d][2] ? x : y);
            wc += sample_tick;
            if (sc == 4) begin
                ra = ra + 49'(d);
                la = lrun ? la + 49'(d) : la;
                aa = aa + 48'(x);
            end
            sc = sc == 4 ? 0 : sc + 1;
            if (psel && penable && !pwrite && idx == 8'h43)
                aa = '0;
            if (psel && penable && pwrite) begin
                sh[idx] = pwdata & wmask(idx);
                cyc = cyc && !(idx == 8'hde && pwdata[2]);
                {lrun, la, lval} = idx == 8'h47 ? '0 : {lrun, la, lval};
            end
            if (zero_cross && !(psel && penable && pwrite && idx == 8'h47)) begin
                if (!lrun) begin
                    lrun = sh[8'h47] != 0;
                    lcnt = 0;
                end else if (lcnt + 1 == sh[8'h47]) begin
                    lval = la[48:25];
                    la = '0;
                    cyc = 1'b1;
                    lcnt = 0;
                end else
                    lcnt++;
            end
        end
    end
    // ----------------
    // tasks
    // ----------------
    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] i, input logic [31:0] v, output logic [31:0] e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= v;
        #1 e = expv(i);
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k == 0 || (pready !== 1'b1 && k < 50); k++)
            @(posedge pclk);
        chk(w ? 32'(pslverr) : prdata, w ? 32'(!(i inside {8'h0d, 8'h0f, [8'hda:8'hdb],
            [8'hdd:8'hde], [8'h40:8'h48]})) : e);
        if (k == 50) begin
            bad_count++;
            print_verdict;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] i, input logic [31:0] v);
        logic [31:0] e;
        apb(1'b1, i, v, e);
    endtask
    task rc(input logic [7:0] i);
        logic [31:0] e;
        apb(1'b0, i, 32'h0, e);
    endtask
    task irq_chk;
        #1 chk({31'h0, energy_irq}, {31'h0, cyc & sh[8'hdb][2]});
    endtask
    task wait_irq;
        int k;
        for (k = 0; k < 1000 && energy_irq !== 1'b1; k++)
            @(posedge pclk);
        if (k == 1000) begin
            chk(32'h0, 32'h1);
            print_verdict;
        end
    endtask
    // ----------------
    // stimulus
    // ----------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {active_power, reactive_power, voltage_rms, current_rms} = '0;
        {active_noload, reactive_noload} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rw[n]) begin
            rc(rw[n]);
            wr(rw[n], $random(seed));
            rc(rw[n]);
        end
        wr(8'h20, 32'h1);
        rc(8'h20);
        $display("registers done");
        for (int m = 0; m < 8; m += 2) begin
            wr(8'h0f, m);
            repeat (3) begin
                @(posedge pclk);
                active_power <= $random(seed);
                reactive_power <= $random(seed);
                active_noload <= 1'($random(seed));
                reactive_noload <= ($random(seed) & 3) == 0;
                repeat (60) @(posedge pclk);
                rc(8'h45);
            end
        end
        $display("reactive modes done");
        wr(8'hdb, 32'h8);
        for (int k = 0; k < 2; k++) begin
            wr(8'h40, $random(seed));
            wr(8'h41, k * 3);
            wr(8'h0d, k * 7);
            @(posedge pclk);
            voltage_rms <= $random(seed);
            current_rms <= $random(seed);
            repeat (200) @(posedge pclk);
            rc(8'h42);
            rc(8'h48);
            rc(8'h43);
            repeat (10) @(posedge pclk);
            rc(8'h42);
        end
        $display("apparent done");
        reactive_noload <= 1'b0;
        active_noload <= 1'b0;
        wr(8'hdb, 32'h4);
        wr(8'h47, 32'h3);
        wr(8'hde, 32'h4);
        rc(8'h46);
        wait_irq;
        irq_chk;
        rc(8'h46);
        rc(8'hde);
        wr(8'hde, 32'h4);
        irq_chk;
        wait_irq;
        rc(8'h46);
        irq_chk;
        $display("line cycle done");
        print_verdict;
    end
endmodule
`default_nettype wire
